// *** rtl/bscp_pkg.sv ***
// Purpose : Shared constants and types for the buck switch control block
// Assumes : 40 MHz control clock
// Notes   : Every timing count is derived from its printed time

package bscp_pkg;

   // ----------------------------------------------------------------------
   // Clock and switch timing
   // ----------------------------------------------------------------------
   localparam int CLK_NS      = 25;
   localparam int MIN_ON_NS   = 110;
   localparam int MIN_OFF_NS  = 80;
   localparam int BLANK_NS    = 100;
   localparam int DEAD_NS     = 25;
   localparam int MIN_ON_CYC  = (MIN_ON_NS + CLK_NS - 1) / CLK_NS;
   localparam int MIN_OFF_CYC = (MIN_OFF_NS + CLK_NS - 1) / CLK_NS;
   localparam int BLANK_CYC   = (BLANK_NS + CLK_NS - 1) / CLK_NS;
   localparam int DEAD_CYC    = (DEAD_NS + CLK_NS - 1) / CLK_NS;
   localparam int OSC_KHZ     = 390;
   localparam int PERIOD_CYC  = 1000000 / (OSC_KHZ * CLK_NS);

   // ----------------------------------------------------------------------
   // Start-up and protection timing
   // ----------------------------------------------------------------------
   localparam int SS_US       = 1500;
   localparam int SS_CYC      = SS_US * 1000 / CLK_NS;
   localparam int SS_LEVELS   = 256;
   localparam int HICCUP_MS   = 30;
   localparam int HICCUP_CYC  = HICCUP_MS * 1000000 / CLK_NS;
   localparam int OC_CYCLES   = 128;
   localparam int CNT_W       = 8;

   localparam logic [CNT_W-1:0] MIN_ON_M1  = CNT_W'(MIN_ON_CYC - 1);
   localparam logic [CNT_W-1:0] BLANK_M1   = CNT_W'(BLANK_CYC - 1);
   localparam logic [CNT_W-1:0] DEAD_M1    = CNT_W'(DEAD_CYC - 1);
   localparam logic [CNT_W-1:0] MIN_OFF_V  = CNT_W'(MIN_OFF_CYC);
   localparam logic [7:0]       OC_LAST    = 8'(OC_CYCLES - 1);

   // ----------------------------------------------------------------------
   // Positions of the synchronised pin and comparator inputs
   // ----------------------------------------------------------------------
   localparam int IN_W        = 13;
   localparam int IX_VARIANT  = 0;
   localparam int IX_EN_HI    = 1;
   localparam int IX_EN_LO    = 2;
   localparam int IX_VIN      = 3;
   localparam int IX_VCC      = 4;
   localparam int IX_HOT      = 5;
   localparam int IX_COOL     = 6;
   localparam int IX_SYNC     = 7;
   localparam int IX_HI_CMP   = 8;
   localparam int IX_HI_LIM   = 9;
   localparam int IX_LO_LIM   = 10;
   localparam int IX_ZC       = 11;
   localparam int IX_NEG      = 12;

   typedef enum logic [2:0] {
      ST_OFF, ST_IDLE, ST_HI_ON, ST_DEAD_HL, ST_LO_ON, ST_DEAD_LH, ST_HICCUP
   } bscp_state_t;

endpackage

// *** rtl/bscp_sync.sv ***
// Purpose : Two-stage synchroniser for a bundle of asynchronous levels
// Assumes : Each bit is an independent slow level
// Notes   : First stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none

module bscp_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_reset_n,
   // Levels
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);

   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   always_comb begin
      meta_d = i_d;
      sync_d = meta_q;
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign o_q = sync_q;

endmodule

`default_nettype wire

// *** rtl/bscp_osc.sv ***
// Purpose : Internal switching oscillator as a one-cycle tick
// Assumes : Held in restart while the converter is not running (run low)
// Notes   : Tick is registered, so it falls one cycle after the last count of each period
`timescale 1ns/100ps
`default_nettype none

module bscp_osc #(
   parameter int PERIOD = 102
) (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_reset_n,
   // Control
   input  wire logic i_run,
   output logic      o_tick
);

   localparam int W = $clog2(PERIOD + 1);
   localparam logic [W-1:0] LAST = W'(PERIOD - 1);

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic         tick_q;
   logic         tick_d;

   always_comb begin
      cnt_d  = cnt_q + 1'b1;
      tick_d = 1'b0;
      if (!i_run) begin
         cnt_d = '0;
      end else if (cnt_q == LAST) begin
         cnt_d  = '0;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign o_tick = tick_q;

endmodule

`default_nettype wire

// *** rtl/bscp_ctrl.sv ***
// Purpose : Switch sequencer and protection for a synchronous step-down stage
// Assumes : All comparator and pin inputs are asynchronous levels
// Notes   : Gates are registered; long counts shortened by parameters
//
// Operation
// RQ1 - Stop when hot, resume below cool level
// RQ2 - Enable below low threshold forces shutdown
// RQ3 - Either supply lockout turns the controller off
// RQ4 - Activate only with enable and both supplies good
// RQ5 - Light-load variant runs discontinuous at light load
// RQ6 - Discontinuous: low switch off at zero cross
// RQ7 - Light-load variant skips cycles at minimum demand
// RQ8 - Sync clock ignored in pulse-frequency mode
// RQ9 - Fixed variant never skips, allows negative current
// RQ10 - Fixed variant always accepts sync clock
// RQ11 - Negative floor hit: low switch off till cycle
// RQ12 - Blank high current compare after high turn-on
// RQ13 - End on-time when current exceeds clamped error
// RQ14 - Hold low switch while above its ceiling
// RQ15 - Low ceiling only after high ceiling trip
// RQ16 - Dead time after low off before high on
// RQ17 - 128 overcurrent cycles: 30 ms off, restart
// RQ18 - Repeated overcurrent repeats a full hiccup
// RQ19 - Every start ramps through 1.5 ms soft-start
// RQ20 - Enforce minimum on-time and minimum off-time
// RQ21 - Accepted sync rising edge starts each cycle
// RQ22 - Dead time after high off before low on
// RQ23 - Static select picks light-load or fixed variant
// RQ24 - Overcurrent count clears on clean cycle, shutdown
`timescale 1ns/100ps
`default_nettype none

module bscp_ctrl #(
   parameter int SS_CYC     = bscp_pkg::SS_CYC,
   parameter int HICCUP_CYC = bscp_pkg::HICCUP_CYC,
   parameter int PERIOD_CYC = bscp_pkg::PERIOD_CYC
) (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_reset_n,
   // Variant strap
   input  wire logic       i_variant_fixed,
   // Enable and supply comparators
   input  wire logic       i_en_above,
   input  wire logic       i_en_below,
   input  wire logic       i_vin_ok,
   input  wire logic       i_vcc_ok,
   // Thermal comparators
   input  wire logic       i_over_temperature_trip,
   input  wire logic       i_temp_cool,
   // External clock on the enable pin
   input  wire logic       i_sync_clk,
   // Current comparators
   input  wire logic       i_hi_cur_over,
   input  wire logic       i_hi_ceiling_trip,
   input  wire logic       i_lo_ceiling_over,
   input  wire logic       i_zero_cross,
   input  wire logic       i_neg_floor,
   input  wire logic       i_light_load,
   // Switch gates
   output logic            o_high_side_switch,
   output logic            o_low_side_switch,
   // Status
   output logic [7:0]      o_ss_level,
   output logic            o_ss_done,
   output logic            o_active,
   output logic            o_pfm,
   output logic            o_hiccup
);

   // ----------------------------------------------------------------------
   // Derived sizes
   // ----------------------------------------------------------------------
   localparam int SS_STEP = SS_CYC / bscp_pkg::SS_LEVELS;
   localparam int SW_W    = $clog2(SS_STEP + 1);
   localparam int HW      = $clog2(HICCUP_CYC + 1);
   localparam int YW      = $clog2(2 * PERIOD_CYC + 1);
   localparam logic [SW_W-1:0] SS_STEP_M1 = SW_W'(SS_STEP - 1);
   localparam logic [HW-1:0]   HIC_LOAD   = HW'(HICCUP_CYC - 1);
   localparam logic [YW-1:0]   SYNC_LOSS  = YW'(2 * PERIOD_CYC);

   // ----------------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------------
   logic [bscp_pkg::IN_W-1:0] in_s;

   bscp_sync #(.W(bscp_pkg::IN_W)) u_sync (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_d       ({i_neg_floor, i_zero_cross, i_lo_ceiling_over,
                   i_hi_ceiling_trip, i_hi_cur_over, i_sync_clk,
                   i_temp_cool, i_over_temperature_trip, i_vcc_ok,
                   i_vin_ok, i_en_below, i_en_above, i_variant_fixed}),
      .o_q       (in_s)
   );

   logic light_s;
   logic light_m_q;
   logic light_q;

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   bscp_pkg::bscp_state_t     st_q, st_d;
   logic                      run_q, run_d;
   logic                      hot_q, hot_d;
   logic                      fixed_q, fixed_d;
   logic                      cap_q, cap_d;
   logic [1:0]                capw_q, capw_d;
   logic                      pend_q, pend_d;
   logic                      armed_q, armed_d;
   logic                      seen_q, seen_d;
   logic [7:0]                oc_q, oc_d;
   logic [bscp_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic [bscp_pkg::CNT_W-1:0] off_q, off_d;
   logic [HW-1:0]             hic_q, hic_d;
   logic [SW_W-1:0]           ssd_q, ssd_d;
   logic [7:0]                ssl_q, ssl_d;
   logic                      syp_q;
   logic [YW-1:0]             syc_q, syc_d;
   logic                      hi_q, lo_q, done_q, act_q, pfm_q, hicq_q;
   logic                      osc_tick, sync_edge, use_sync, tick, lo_oc;
   logic                      stop_lo, on_ok;

   bscp_osc #(.PERIOD(PERIOD_CYC)) u_osc (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_run     (run_q),
      .o_tick    (osc_tick)
   );

   // ----------------------------------------------------------------------
   // Cycle source
   // ----------------------------------------------------------------------
   always_comb begin
      light_s   = light_q;
      sync_edge = in_s[bscp_pkg::IX_SYNC] & ~syp_q;
      // Sync counts as present while edges keep coming
      syc_d     = sync_edge ? '0 : ((syc_q == SYNC_LOSS) ? syc_q : syc_q + 1'b1);
      use_sync  = (syc_q != SYNC_LOSS) & (fixed_q | ~pfm_q); // RQ8 RQ10
      tick      = use_sync ? sync_edge : osc_tick; // RQ21
      lo_oc     = armed_q & in_s[bscp_pkg::IX_LO_LIM]; // RQ15
   end

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   always_comb begin
      st_d    = st_q;
      hot_d   = hot_q;
      run_d   = run_q;
      fixed_d = fixed_q;
      // Strap is only valid once the synchroniser has filled
      cap_d   = cap_q | (capw_q == 2'h2); // RQ23
      capw_d  = (capw_q == 2'h2) ? capw_q : capw_q + 2'h1;
      pend_d  = pend_q;
      armed_d = armed_q;
      seen_d  = seen_q;
      oc_d    = oc_q;
      cnt_d   = cnt_q + 1'b1;
      off_d   = (off_q == bscp_pkg::MIN_OFF_V) ? off_q : off_q + 1'b1;
      hic_d   = hic_q;
      stop_lo = 1'b0;
      on_ok   = 1'b0;
      // Strap is caught once, after reset release
      if (!cap_q) fixed_d = in_s[bscp_pkg::IX_VARIANT]; // RQ23
      if (in_s[bscp_pkg::IX_HOT]) hot_d = 1'b1; // RQ1
      else if (in_s[bscp_pkg::IX_COOL]) hot_d = 1'b0; // RQ1
      if (!run_q) begin
         run_d = in_s[bscp_pkg::IX_EN_HI] & in_s[bscp_pkg::IX_VIN]
               & in_s[bscp_pkg::IX_VCC] & ~hot_q & cap_q; // RQ4
      end else if (in_s[bscp_pkg::IX_EN_LO] | ~in_s[bscp_pkg::IX_VIN]
                   | ~in_s[bscp_pkg::IX_VCC] | hot_q) begin
         run_d = 1'b0; // RQ2 RQ3 RQ1
      end
      // Cycle skipping only in the light-load variant
      if (tick & ~(~fixed_q & light_s)) pend_d = 1'b1; // RQ7 RQ9
      case (st_q)
         bscp_pkg::ST_OFF: begin
            oc_d    = '0; // RQ24
            armed_d = 1'b0;
            pend_d  = 1'b0;
            if (run_q) st_d = bscp_pkg::ST_IDLE; // RQ19
         end
         bscp_pkg::ST_IDLE: begin
            if (pend_q) begin
               st_d  = bscp_pkg::ST_DEAD_LH;
               cnt_d = '0;
            end
         end
         bscp_pkg::ST_HI_ON: begin
            off_d = '0;
            // Compare ignored during blanking and minimum on-time
            if (cnt_q >= bscp_pkg::MIN_ON_M1 && cnt_q >= bscp_pkg::BLANK_M1) begin // RQ12 RQ20
               if (in_s[bscp_pkg::IX_HI_CMP] | in_s[bscp_pkg::IX_HI_LIM] | pend_q) begin // RQ13
                  st_d  = bscp_pkg::ST_DEAD_HL;
                  cnt_d = '0;
               end
            end
            if (in_s[bscp_pkg::IX_HI_LIM]) armed_d = 1'b1; // RQ15
         end
         bscp_pkg::ST_DEAD_HL: begin
            if (cnt_q >= bscp_pkg::DEAD_M1) begin // RQ22
               st_d  = bscp_pkg::ST_LO_ON;
               cnt_d = '0;
            end
         end
         bscp_pkg::ST_LO_ON: begin
            if (lo_oc) seen_d = 1'b1;
            stop_lo = fixed_q ? in_s[bscp_pkg::IX_NEG] // RQ11
                              : in_s[bscp_pkg::IX_ZC]; // RQ5 RQ6
            if (stop_lo && !lo_oc) begin
               st_d = bscp_pkg::ST_IDLE;
            end else if (pend_q && !lo_oc) begin // RQ14
               st_d  = bscp_pkg::ST_DEAD_LH;
               cnt_d = '0;
            end
         end
         bscp_pkg::ST_DEAD_LH: begin
            on_ok = (cnt_q >= bscp_pkg::DEAD_M1) && (off_q == bscp_pkg::MIN_OFF_V); // RQ16 RQ20
            if (on_ok) begin
               // A start request arriving now is kept, not lost
               pend_d = tick & ~(~fixed_q & light_s); // RQ21
               seen_d = 1'b0;
               cnt_d  = '0;
               st_d   = bscp_pkg::ST_HI_ON;
               if (!seen_q) begin
                  oc_d    = '0; // RQ24
                  armed_d = 1'b0;
               end else if (oc_q == bscp_pkg::OC_LAST) begin
                  oc_d  = '0; // RQ17
                  st_d  = bscp_pkg::ST_HICCUP;
                  hic_d = HIC_LOAD;
               end else begin
                  oc_d = oc_q + 1'b1;
               end
            end
         end
         bscp_pkg::ST_HICCUP: begin
            pend_d  = 1'b0;
            armed_d = 1'b0;
            hic_d   = hic_q - 1'b1;
            // Restart goes through soft-start again
            if (hic_q == '0) st_d = bscp_pkg::ST_IDLE; // RQ17 RQ18
         end
         default: st_d = bscp_pkg::ST_OFF;
      endcase
      if (!run_q) st_d = bscp_pkg::ST_OFF; // RQ1 RQ2 RQ3
   end

   // ----------------------------------------------------------------------
   // Soft-start ramp
   // ----------------------------------------------------------------------
   always_comb begin
      ssd_d = ssd_q;
      ssl_d = ssl_q;
      if (st_q == bscp_pkg::ST_OFF || st_q == bscp_pkg::ST_HICCUP) begin
         ssd_d = '0; // RQ19
         ssl_d = '0;
      end else if (ssl_q != 8'hff) begin
         ssd_d = ssd_q + 1'b1;
         if (ssd_q == SS_STEP_M1) begin
            ssd_d = '0;
            ssl_d = ssl_q + 8'h01; // RQ19
         end
      end
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_q    <= bscp_pkg::ST_OFF;
         run_q   <= 1'b0;
         hot_q   <= 1'b0;
         fixed_q <= 1'b0;
         cap_q   <= 1'b0;
         capw_q  <= 2'h0;
         pend_q  <= 1'b0;
         armed_q <= 1'b0;
         seen_q  <= 1'b0;
         oc_q    <= '0;
         cnt_q   <= '0;
         off_q   <= '0;
         hic_q   <= '0;
         ssd_q   <= '0;
         ssl_q   <= '0;
         syp_q   <= 1'b0;
         syc_q   <= '0;
         light_m_q <= 1'b0;
         light_q <= 1'b0;
         hi_q    <= 1'b0;
         lo_q    <= 1'b0;
         done_q  <= 1'b0;
         act_q   <= 1'b0;
         pfm_q   <= 1'b0;
         hicq_q  <= 1'b0;
      end else begin
         st_q    <= st_d;
         run_q   <= run_d;
         hot_q   <= hot_d;
         fixed_q <= fixed_d;
         cap_q   <= cap_d;
         capw_q  <= capw_d;
         pend_q  <= pend_d;
         armed_q <= armed_d;
         seen_q  <= seen_d;
         oc_q    <= oc_d;
         cnt_q   <= cnt_d;
         off_q   <= off_d;
         hic_q   <= hic_d;
         ssd_q   <= ssd_d;
         ssl_q   <= ssl_d;
         syp_q   <= in_s[bscp_pkg::IX_SYNC];
         syc_q   <= syc_d;
         light_m_q <= i_light_load;
         light_q <= light_m_q;
         hi_q    <= (st_d == bscp_pkg::ST_HI_ON);
         lo_q    <= (st_d == bscp_pkg::ST_LO_ON);
         done_q  <= (ssl_d == 8'hff);
         act_q   <= (st_d != bscp_pkg::ST_OFF) && (st_d != bscp_pkg::ST_HICCUP);
         pfm_q   <= ~fixed_d & light_s & run_d;
         hicq_q  <= (st_d == bscp_pkg::ST_HICCUP);
      end
   end

   assign o_high_side_switch = hi_q;
   assign o_low_side_switch  = lo_q;
   assign o_ss_level         = ssl_q;
   assign o_ss_done          = done_q;
   assign o_active           = act_q;
   assign o_pfm              = pfm_q;
   assign o_hiccup           = hicq_q;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   sequence s_gates_off;
      !hi_q && !lo_q;
   endsequence

   a_no_overlap: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ22
      !(hi_q && lo_q)) else $error("Both switches on");
   a_dead_hi_lo: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ22
      $fell(hi_q) |-> !lo_q ##1 1'b1) else $error("No dead time after high off");
   a_dead_lo_hi: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ16
      $fell(lo_q) |-> !hi_q) else $error("No dead time after low off");
   a_min_on_time: assert property (@(posedge i_clk) disable iff (!i_reset_n || !run_q) // RQ20
      $rose(hi_q) |-> hi_q[*5]) else $error("High on-time too short");
   a_min_off_time: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ20
      $fell(hi_q) |-> !hi_q[*4]) else $error("High off-time too short");
   a_en_shutdown: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ2
      in_s[bscp_pkg::IX_EN_LO] |-> ##2 s_gates_off) else $error("Enable low not obeyed");
   a_hot_shutdown: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ1
      in_s[bscp_pkg::IX_HOT] |-> ##3 s_gates_off) else $error("Over-temperature not obeyed");
   a_hiccup_off: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ17
      $rose(hicq_q) |-> s_gates_off[*8]) else $error("Switching during hiccup");
   a_neg_floor_off: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ11
      (st_q == bscp_pkg::ST_LO_ON && fixed_q && in_s[bscp_pkg::IX_NEG] && !lo_oc)
      |=> !lo_q) else $error("Low switch kept on past negative floor");
   a_oc_clear: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ24
      (st_q == bscp_pkg::ST_DEAD_LH && on_ok && !seen_q) |=> oc_q == 8'h00)
      else $error("Overcurrent count not cleared");
   a_pfm_no_sync: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ8
      (!fixed_q && pfm_q && light_s && !pend_q) |=> !pend_q)
      else $error("Cycle started in pulse-frequency mode");
   a_pfm_sync_off: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ8
      (pfm_q && !fixed_q && sync_edge && !osc_tick) |-> !tick)
      else $error("Sync edge used in pulse-frequency mode");

endmodule

`default_nettype wire

// *** tb/bscp_stage_model.sv ***
// Purpose : Power stage and current comparators seen by the sequencer
// Assumes : Inductor current rises at once after high turn-on
// Notes   : i_short models a hard output short for the hiccup path
`timescale 1ns/100ps
`default_nettype none

module bscp_stage_model (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_reset_n,
   // Gates and fault knob
   input  wire logic i_high,
   input  wire logic i_low,
   input  wire logic i_short,
   // Comparators
   output logic      o_hi_cur_over,
   output logic      o_hi_ceiling_trip,
   output logic      o_lo_ceiling_over,
   output logic      o_zero_cross,
   output logic      o_neg_floor
);
   logic [7:0] hi_cnt_q;
   logic [7:0] lo_cnt_q;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         hi_cnt_q <= 8'h00;
         lo_cnt_q <= 8'h00;
      end else begin
         hi_cnt_q <= i_high ? hi_cnt_q + 8'h01 : 8'h00;
         lo_cnt_q <= i_low ? lo_cnt_q + 8'h01 : 8'h00;
      end
   end

   // Trips early on purpose, so blanking must hide it
   assign o_hi_cur_over     = i_high && (hi_cnt_q >= 8'h01);
   assign o_hi_ceiling_trip = i_short && i_high;
   // Valley stays high briefly, so cycles still complete
   assign o_lo_ceiling_over = i_short && i_low && (lo_cnt_q < 8'h03);
   assign o_zero_cross      = !i_short && i_low && (lo_cnt_q >= 8'h06);
   // Floor trips after zero cross, so the variants differ
   assign o_neg_floor       = !i_short && i_low && (lo_cnt_q >= 8'h08);
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Purpose : Self-checking bench for the buck switch sequencer
// Assumes : Short parameters for soft-start, hiccup and period
// Notes   : Sync pin toggled by a task; gate shape checked by a monitor
`timescale 1ns/100ps
`default_nettype none

module tb;
   logic clk, reset_n, fixed, en_above, en_below, vin_ok, vcc_ok;
   logic hot, cool, light, shorted, sync, o_high, o_low, o_ss_done;
   logic o_active, o_pfm, o_hiccup, hcur, hceil, lceil, zc, neg;
   logic [7:0] o_ss_level;
   logic prev_high, prev_low;
   int bad_count, compares, hi_len, lo_len, lo_last, pulses, n;

   bscp_ctrl #(.SS_CYC(256), .HICCUP_CYC(200), .PERIOD_CYC(20)) i_bscp_ctrl (
      .i_clk(clk), .i_reset_n(reset_n), .i_variant_fixed(fixed),
      .i_en_above(en_above), .i_en_below(en_below), .i_vin_ok(vin_ok),
      .i_vcc_ok(vcc_ok), .i_over_temperature_trip(hot), .i_temp_cool(cool),
      .i_sync_clk(sync), .i_hi_cur_over(hcur), .i_hi_ceiling_trip(hceil),
      .i_lo_ceiling_over(lceil), .i_zero_cross(zc), .i_neg_floor(neg),
      .i_light_load(light), .o_high_side_switch(o_high), .o_low_side_switch(o_low),
      .o_ss_level(o_ss_level), .o_ss_done(o_ss_done), .o_active(o_active),
      .o_pfm(o_pfm), .o_hiccup(o_hiccup));

   bscp_stage_model i_bscp_stage_model (
      .i_clk(clk), .i_reset_n(reset_n), .i_high(o_high), .i_low(o_low),
      .i_short(shorted), .o_hi_cur_over(hcur), .o_hi_ceiling_trip(hceil),
      .o_lo_ceiling_over(lceil), .o_zero_cross(zc), .o_neg_floor(neg));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic chk(input string name, input logic exp, input logic got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic give_verdict();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Gate shape monitor
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      #1;
      if (reset_n !== 1'b1) begin
         hi_len = 0;
         lo_len = 0;
      end else begin
         chk("both_gates_on", 1'b0, o_high & o_low);
         if (o_low === 1'b1 && prev_low === 1'b0) chk("dead_hl", 1'b0, prev_high);
         if (o_high === 1'b1 && prev_high === 1'b0) chk("dead_lh", 1'b0, prev_low);
         if (o_low === 1'b1) lo_len++;
         else if (lo_len != 0) begin
            lo_last = lo_len;
            lo_len = 0;
         end
         if (o_high === 1'b1) hi_len++;
         else if (hi_len != 0) begin
            chk("min_on_blank", 1'b1, hi_len >= 5);
            pulses++;
            hi_len = 0;
         end
      end
      prev_high = o_high;
      prev_low = o_low;
   end

   task automatic do_reset(input logic var_fixed);
      reset_n <= 1'b0;
      fixed <= var_fixed;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      chk("gates_reset", 1'b0, o_high | o_low);
   endtask

   task automatic s_start();
      en_above <= 1'b1;
      vin_ok <= 1'b1;
      vcc_ok <= 1'b1;
      for (n = 0; n < 40 && o_active !== 1'b1; n++) @(posedge clk);
      chk("active_start", 1'b1, o_active);
      for (n = 0; n < 400 && o_ss_done !== 1'b1; n++) @(posedge clk);
      chk("ss_done", 1'b1, o_ss_done);
      chk("ss_level", 1'b1, o_ss_level == 8'hff);
   endtask

   task automatic sync_run(input int periods);
      for (int k = 0; k < periods; k++) begin
         sync <= 1'b1;
         repeat (8) @(posedge clk);
         sync <= 1'b0;
         repeat (8) @(posedge clk);
      end
   endtask

   task automatic s_sync();
      sync_run(10);
      pulses = 0;
      sync_run(20);
      chk("sync_cycles", 1'b1, pulses >= 19);
   endtask

   task automatic s_fixed_light();
      light <= 1'b1;
      pulses = 0;
      repeat (300) @(posedge clk);
      chk("fixed_no_skip", 1'b1, pulses >= 10);
      chk("fixed_no_pfm", 1'b0, o_pfm);
      chk("fixed_neg_floor", 1'b1, lo_last >= 10);
      light <= 1'b0;
   endtask

   task automatic s_pfm();
      light <= 1'b1;
      for (n = 0; n < 100 && o_pfm !== 1'b1; n++) @(posedge clk);
      chk("pfm_entered", 1'b1, o_pfm);
      pulses = 0;
      sync_run(10);
      chk("pfm_skips", 1'b1, pulses <= 1);
      light <= 1'b0;
      repeat (20) @(posedge clk);
      pulses = 0;
      repeat (300) @(posedge clk);
      chk("dcm_switching", 1'b1, pulses >= 10);
      chk("dcm_zero_cross", 1'b1, lo_last <= 9);
   endtask

   task automatic s_hiccup();
      shorted <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         for (n = 0; n < 5000 && o_hiccup !== 1'b1; n++) @(posedge clk);
         chk("hiccup_on", 1'b1, o_hiccup);
         repeat (100) @(posedge clk);
         chk("hiccup_gates", 1'b0, o_high | o_low);
         for (n = 0; n < 150 && o_hiccup !== 1'b0; n++) @(posedge clk);
         chk("hiccup_off", 1'b0, o_hiccup);
      end
      shorted <= 1'b0;
   endtask

   task automatic s_thermal();
      hot <= 1'b1;
      cool <= 1'b0;
      repeat (8) @(posedge clk);
      chk("hot_off", 1'b0, o_active | o_high | o_low);
      hot <= 1'b0;
      repeat (30) @(posedge clk);
      chk("hot_latched", 1'b0, o_active);
      cool <= 1'b1;
      for (n = 0; n < 40 && o_active !== 1'b1; n++) @(posedge clk);
      chk("cool_restart", 1'b1, o_active);
      chk("restart_ramp", 1'b0, o_ss_done);
      chk("restart_level", 1'b1, o_ss_level < 8'h10);
   endtask

   task automatic s_shutdown(input int which);
      en_above <= (which != 0);
      en_below <= (which == 0);
      vin_ok <= (which != 1);
      vcc_ok <= (which != 2);
      repeat (8) @(posedge clk);
      chk("shutdown_gates", 1'b0, o_active | o_high | o_low);
      en_below <= 1'b0;
      s_start();
   endtask

   initial begin
      {reset_n, fixed, en_above, en_below, vin_ok, vcc_ok} = 6'h00;
      {hot, light, shorted, sync} = 4'h0;
      cool = 1'b1;
      bad_count = 0;
      compares = 0;
      hi_len = 0;
      lo_len = 0;
      lo_last = 0;
      pulses = 0;
      do_reset(1'b1);
      s_start();
      s_fixed_light();
      s_sync();
      s_hiccup();
      s_thermal();
      for (int w = 0; w < 3; w++) s_shutdown(w);
      do_reset(1'b0);
      s_start();
      s_pfm();
      give_verdict();
   end

   // Bound covers two hiccups plus all other scenarios with margin
   initial begin
      repeat (60000) @(posedge clk);
      bad_count++;
      give_verdict();
   end
endmodule
`default_nettype wire
